// file: hw/motor_driver_fault_responder.v
`timescale 1ns/100ps
`include "fault_responder_defs.vh"

// Contract
// - Buck overcurrent past deglitch time puts the block into its reset state
// - Comparator on sense output against pulse limit raises a pulse limit event
// - Threshold is closed-loop setting in closed loop, open-loop setting otherwise
// - Modes 000x recirculate, set pulse flag, resume and clear at next PWM cycle
// - Mode 0000 also sets control error and fault pin until next PWM cycle
// - Modes 001x recirculate while above threshold; only 0010 reports error
// - Modes 010x recirculate for retry count plus one PWM cycles; 0100 reports
// - Mode 0110 keeps driving, flags latch until condition gone and clear command
// - Mode 0111 and 1xxx ignore pulse limit events entirely
// - Sense above lock threshold past lock deglitch time raises a lock event
// - Lock modes 0xxx: low bits pick off, recirculate, high or low brake
// - Lock modes 00xx latch fault pin and flags until clear and condition gone
// - Lock modes 01xx recover, release pin and clear flags after retry wait
// - Lock mode 1000 keeps driving, flags latch until clear and condition gone
// - Lock modes 1xx1 ignore lock events entirely
// - Warning temperature sets warning flags; fault pin only with report enable
// - Warning pin drops below hysteresis; flag clears by command below limit
// - Warning report enable resets to off
// - Shutdown temperature: bridge off, charge pump off, pin low, three flags set
// - Shutdown always active, resumes below hysteresis, flag latched until clear
module motor_driver_fault_responder
(
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        buck_ocp_raw,
   input  wire        temp_warn_raw,
   input  wire        temp_warn_hys_raw,
   input  wire        temp_tsd_raw,
   input  wire        temp_tsd_hys_raw,
   input  wire [7:0]  sense_amp_output,
   input  wire        pwm_cycle_start,
   input  wire        closed_loop,
   input  wire [7:0]  closed_loop_limit_setting,
   input  wire [7:0]  open_loop_limit_setting,
   input  wire [3:0]  pulse_limit_response_select,
   input  wire [2:0]  pulse_limit_retry_cycles,
   input  wire [7:0]  lock_current_threshold,
   input  wire [15:0] lock_current_deglitch_time,
   input  wire [3:0]  lock_current_response_select,
   input  wire [23:0] lock_recovery_wait,
   input  wire        cfg_write,
   input  wire        cfg_warning_report,
   input  wire        clear_faults_cmd,
   output reg         fault_out_n,
   output reg  [2:0]  bridge_state,
   output reg         charge_pump_enable,
   output reg         reset_request,
   output reg         warning_report_enable,
   output reg         pulse_current_limit_flag,
   output reg         lock_current_flag,
   output reg         control_error_flag,
   output reg         power_stage_error_flag,
   output reg         overtemperature_any_flag,
   output reg         thermal_warning_flag,
   output reg         thermal_shutdown_flag
);

   localparam [1:0] LK_IDLE   = 2'h0;
   localparam [1:0] LK_LATCH  = 2'h1;
   localparam [1:0] LK_RETRY  = 2'h2;
   localparam [1:0] LK_REPORT = 2'h3;

   localparam [15:0] BUCK_DEG_LIMIT = `BUCK_OCP_DEG_CYC;

   wire [`SY_WIDTH-1:0] sync_q;
   wire                 buck_det;
   wire                 lock_det;
   wire                 srst;
   wire                 warn_s;
   wire                 warn_hys_s;
   wire                 tsd_s;
   wire                 tsd_hys_s;
   wire [7:0]           pulse_thr;
   wire [2:0]           pl_grp;
   wire                 pl_ignore;
   wire                 lk_ignore;

   reg                  buck_rst_ff;
   reg                  pl_over_ff;
   reg                  lk_over_ff;
   reg                  pl_active_ff;
   reg                  pl_report_ff;
   reg  [3:0]           pl_cnt_ff;
   reg  [1:0]           lk_state_ff;
   reg  [1:0]           lk_br_ff;
   reg  [23:0]          lk_cnt_ff;
   reg                  warn_pin_ff;
   reg                  tsd_active_ff;
   reg  [2:0]           nxt_bridge;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and deglitch timers

   two_flop_sync #(.W(`SY_WIDTH)) u_sync
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d_async ({temp_tsd_hys_raw, temp_tsd_raw, temp_warn_hys_raw,
                 temp_warn_raw, buck_ocp_raw}),
      .q_sync  (sync_q)
   );

   assign warn_s     = sync_q[`SY_WARN];
   assign warn_hys_s = sync_q[`SY_WARN_HYS];
   assign tsd_s      = sync_q[`SY_TSD];
   assign tsd_hys_s  = sync_q[`SY_TSD_HYS];

   deglitch_timer #(.W(16)) u_buck_deg
   (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .level_in (sync_q[`SY_BUCK]),
      .limit    (BUCK_DEG_LIMIT),
      .detected (buck_det)
   );

   deglitch_timer #(.W(16)) u_lock_deg
   (
      .clk_sys  (clk_sys),
      .rst      (srst),
      .level_in (lk_over_ff),
      .limit    (lock_current_deglitch_time),
      .detected (lock_det)
   );

   ////////////////////////////////////////////////////////////////////////
   // Buck overcurrent reset; held while the overcurrent lasts

   always @(posedge clk_sys)
   begin
      if (rst)
         buck_rst_ff <= 1'b0;
      else
         buck_rst_ff <= buck_det;
   end

   assign srst = rst | buck_rst_ff;

   ////////////////////////////////////////////////////////////////////////
   // Current comparators on the sense output

   assign pulse_thr = closed_loop ? closed_loop_limit_setting
                                  : open_loop_limit_setting;

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         pl_over_ff <= 1'b0;
         lk_over_ff <= 1'b0;
      end
      else
      begin
         pl_over_ff <= (sense_amp_output > pulse_thr);
         lk_over_ff <= (sense_amp_output > lock_current_threshold);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pulse current limit

   assign pl_grp    = pulse_limit_response_select[3:1];
   assign pl_ignore = pulse_limit_response_select[3] |
                      (pulse_limit_response_select == 4'h7);

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         pl_active_ff <= 1'b0;
         pl_report_ff <= 1'b0;
         pl_cnt_ff    <= 4'h0;
      end
      else
      begin
         case (pl_grp)
            `PL_GRP_NEXT:
            begin
               // Event wins over the cycle boundary in the same clock
               if (pl_over_ff)
                  pl_active_ff <= 1'b1;
               else if (pwm_cycle_start)
                  pl_active_ff <= 1'b0;
            end
            `PL_GRP_THRESH:
            begin
               pl_active_ff <= pl_over_ff;
            end
            `PL_GRP_RETRY:
            begin
               if (pl_over_ff && !pl_active_ff)
               begin
                  pl_active_ff <= 1'b1;
                  pl_cnt_ff    <= {1'b0, pulse_limit_retry_cycles} + 4'h1;
               end
               else if (pl_active_ff && pwm_cycle_start)
               begin
                  if (pl_cnt_ff == 4'h1)
                     pl_active_ff <= 1'b0;
                  pl_cnt_ff <= pl_cnt_ff - 4'h1;
               end
            end
            default:
            begin
               pl_active_ff <= 1'b0;
            end
         endcase
         // Report latch; a fresh event beats the clear command
         if (pl_over_ff &&
             pulse_limit_response_select == `PL_MODE_REPORT)
            pl_report_ff <= 1'b1;
         else if (clear_faults_cmd && !pl_over_ff)
            pl_report_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lock current limit

   assign lk_ignore = lock_current_response_select[3] &
                      lock_current_response_select[0];

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         lk_state_ff <= LK_IDLE;
         lk_br_ff    <= `LK_BR_OFF;
         lk_cnt_ff   <= 24'h00_0000;
      end
      else
      begin
         case (lk_state_ff)
            LK_IDLE:
            begin
               if (lock_det && !lk_ignore)
               begin
                  if (!lock_current_response_select[3])
                  begin
                     lk_br_ff <= lock_current_response_select[1:0];
                     if (lock_current_response_select[2])
                     begin
                        lk_state_ff <= LK_RETRY;
                        lk_cnt_ff   <= lock_recovery_wait;
                     end
                     else
                        lk_state_ff <= LK_LATCH;
                  end
                  else if (lock_current_response_select == `LK_MODE_REPORT)
                     lk_state_ff <= LK_REPORT;
               end
            end
            LK_LATCH:
            begin
               if (clear_faults_cmd && !lk_over_ff)
                  lk_state_ff <= LK_IDLE;
            end
            LK_RETRY:
            begin
               if (lk_cnt_ff == 24'h00_0000)
                  lk_state_ff <= LK_IDLE;
               else
                  lk_cnt_ff <= lk_cnt_ff - 24'h00_0001;
            end
            LK_REPORT:
            begin
               if (clear_faults_cmd && !lk_over_ff)
                  lk_state_ff <= LK_IDLE;
            end
            default:
            begin
               lk_state_ff <= LK_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Thermal warning and shutdown

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         warning_report_enable    <= 1'b0;
         warn_pin_ff              <= 1'b0;
         tsd_active_ff            <= 1'b0;
         thermal_warning_flag     <= 1'b0;
         thermal_shutdown_flag    <= 1'b0;
         overtemperature_any_flag <= 1'b0;
         power_stage_error_flag   <= 1'b0;
      end
      else
      begin
         if (cfg_write)
            warning_report_enable <= cfg_warning_report;
         if (warn_s && warning_report_enable)
            warn_pin_ff <= 1'b1;
         else if (!warn_hys_s)
            warn_pin_ff <= 1'b0;
         if (warn_s)
            thermal_warning_flag <= 1'b1;
         else if (clear_faults_cmd)
            thermal_warning_flag <= 1'b0;
         // Shutdown cannot be masked by any setting
         if (tsd_s)
            tsd_active_ff <= 1'b1;
         else if (!tsd_hys_s)
            tsd_active_ff <= 1'b0;
         if (tsd_s)
            thermal_shutdown_flag <= 1'b1;
         else if (clear_faults_cmd)
            thermal_shutdown_flag <= 1'b0;
         if (warn_s || tsd_s)
            overtemperature_any_flag <= 1'b1;
         else if (clear_faults_cmd)
            overtemperature_any_flag <= 1'b0;
         if (tsd_s)
            power_stage_error_flag <= 1'b1;
         else if (clear_faults_cmd && !tsd_active_ff)
            power_stage_error_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bridge state arbitration, most protective first

   always @*
   begin
      nxt_bridge = `BR_NORMAL;
      if (tsd_active_ff)
         nxt_bridge = `BR_OFF;
      else if ((lk_state_ff == LK_LATCH) || (lk_state_ff == LK_RETRY))
      begin
         case (lk_br_ff)
            `LK_BR_OFF:    nxt_bridge = `BR_OFF;
            `LK_BR_RECIRC: nxt_bridge = `BR_RECIRC;
            `LK_BR_HS:     nxt_bridge = `BR_HS_BRAKE;
            `LK_BR_LS:     nxt_bridge = `BR_LS_BRAKE;
            default:       nxt_bridge = `BR_OFF;
         endcase
         // A pending pulse limit never weakens a brake or an off state
      end
      else if (pl_active_ff)
         nxt_bridge = `BR_RECIRC;
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         bridge_state             <= `BR_NORMAL;
         fault_out_n              <= 1'b1;
         charge_pump_enable       <= 1'b1;
         pulse_current_limit_flag <= 1'b0;
         lock_current_flag        <= 1'b0;
         control_error_flag       <= 1'b0;
      end
      else
      begin
         bridge_state       <= nxt_bridge;
         charge_pump_enable <= ~tsd_active_ff;
         fault_out_n <= ~((pl_active_ff & ~pulse_limit_response_select[0] &
                           ~pl_ignore) |
                          (lk_state_ff == LK_LATCH) |
                          (lk_state_ff == LK_RETRY) |
                          warn_pin_ff | tsd_active_ff);
         pulse_current_limit_flag <= pl_active_ff | pl_report_ff;
         lock_current_flag  <= (lk_state_ff != LK_IDLE);
         control_error_flag <= (pl_active_ff & ~pulse_limit_response_select[0]
                                & ~pl_ignore) | pl_report_ff |
                               (lk_state_ff != LK_IDLE);
      end
   end

   always @(posedge clk_sys)
   begin
      if (rst)
         reset_request <= 1'b0;
      else
         reset_request <= buck_det;
   end

endmodule

// file: hw/fault_responder_defs.vh
`ifndef FAULT_RESPONDER_DEFS_VH
`define FAULT_RESPONDER_DEFS_VH

// Clock and timing
`define CLK_PERIOD_NS       50
`define BUCK_OCP_DEG_NS     1000
`define BUCK_OCP_DEG_CYC    ((`BUCK_OCP_DEG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Bridge states
`define BR_NORMAL           3'h0
`define BR_RECIRC           3'h1
`define BR_HS_BRAKE         3'h2
`define BR_LS_BRAKE         3'h3
`define BR_OFF              3'h4

// Lock low mode bits
`define LK_BR_OFF           2'h0
`define LK_BR_RECIRC        2'h1
`define LK_BR_HS            2'h2
`define LK_BR_LS            2'h3

// Pulse limit response select groups
`define PL_GRP_NEXT         3'h0
`define PL_GRP_THRESH       3'h1
`define PL_GRP_RETRY        3'h2
`define PL_MODE_REPORT      4'h6

// Lock response select values
`define LK_MODE_REPORT      4'h8

// Synchroniser bit positions
`define SY_BUCK             0
`define SY_WARN             1
`define SY_WARN_HYS         2
`define SY_TSD              3
`define SY_TSD_HYS          4
`define SY_WIDTH            5

`endif

// file: hw/two_flop_sync.v
`timescale 1ns/100ps
module two_flop_sync
#(
   parameter W = 1
)
(
   input  wire         clk_sys,
   input  wire         rst,
   input  wire [W-1:0] d_async,
   output reg  [W-1:0] q_sync
);

   reg [W-1:0] meta_ff;

   // Only the second stage is read outside
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         meta_ff <= {W{1'b0}};
         q_sync  <= {W{1'b0}};
      end
      else
      begin
         meta_ff <= d_async;
         q_sync  <= meta_ff;
      end
   end

endmodule

// file: hw/deglitch_timer.v
`timescale 1ns/100ps
module deglitch_timer
#(
   parameter W = 16
)
(
   input  wire         clk_sys,
   input  wire         rst,
   input  wire         level_in,
   input  wire [W-1:0] limit,
   output reg          detected
);

   reg [W-1:0] count_ff;

   // Detects once the level has stood longer than limit cycles
   always @(posedge clk_sys)
   begin
      if (rst || !level_in)
      begin
         count_ff <= {W{1'b0}};
         detected <= 1'b0;
      end
      else if (count_ff == limit)
      begin
         detected <= 1'b1;
      end
      else
      begin
         count_ff <= count_ff + {{(W-1){1'b0}}, 1'b1};
      end
   end

endmodule

// file: verif/power_stage_model.sv
`timescale 1ns/100ps
`include "fault_responder_defs.vh"
module power_stage_model
#(
   parameter PWM_PERIOD = 32
)
(
   input  wire       clk_sys,
   input  wire       rst,
   input  wire [2:0] bridge_state,
   input  wire [7:0] sense_level,
   output reg  [7:0] sense_amp_output,
   output reg        pwm_cycle_start
);
   reg [7:0] pwm_cnt_ff;
   ////////////////////////////////////////
   // With all FETs off the phase current decays, so the sense code drops
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         pwm_cnt_ff       <= 8'h00;
         pwm_cycle_start  <= 1'b0;
         sense_amp_output <= 8'h00;
      end
      else
      begin
         pwm_cnt_ff       <= (pwm_cnt_ff == PWM_PERIOD - 1) ? 8'h00
                                                            : pwm_cnt_ff + 8'h01;
         pwm_cycle_start  <= (pwm_cnt_ff == 8'h00);
         sense_amp_output <= (bridge_state == `BR_OFF) ? 8'h00 : sense_level;
      end
   end
endmodule

// file: verif/fault_responder_assertions.sv
`timescale 1ns/100ps
`include "fault_responder_defs.vh"
module fault_responder_assertions
(
   input wire       clk_sys,
   input wire       rst,
   input wire [7:0] sense_amp_output,
   input wire       closed_loop,
   input wire [7:0] closed_loop_limit_setting,
   input wire [7:0] open_loop_limit_setting,
   input wire [3:0] pulse_limit_response_select,
   input wire       clear_faults_cmd,
   input wire       fault_out_n,
   input wire [2:0] bridge_state,
   input wire       charge_pump_enable,
   input wire       reset_request,
   input wire       warning_report_enable,
   input wire       pulse_current_limit_flag,
   input wire       lock_current_flag,
   input wire       control_error_flag,
   input wire       power_stage_error_flag,
   input wire       overtemperature_any_flag,
   input wire       thermal_warning_flag,
   input wire       thermal_shutdown_flag
);
   // History of over-threshold samples covers the event pipeline depth
   reg  [5:0] over_hist_ff;
   wire [7:0] thr = closed_loop ? closed_loop_limit_setting
                                : open_loop_limit_setting;
   wire [5:0] nxt_over_hist = {over_hist_ff[4:0], sense_amp_output > thr};
   always @(posedge clk_sys)
      over_hist_ff <= nxt_over_hist;
   default clocking cb @(posedge clk_sys); endclocking
   ////////////////////////////////////////
   a_rst_values: assert property (
      rst |=> fault_out_n && bridge_state == `BR_NORMAL && charge_pump_enable
         && !warning_report_enable && !pulse_current_limit_flag
         && !lock_current_flag && !thermal_shutdown_flag)
      else $error("outputs not at reset values");
   a_buck_reset: assert property (disable iff (rst)
      reset_request |-> ##2 fault_out_n && !control_error_flag
         && !pulse_current_limit_flag && !lock_current_flag)
      else $error("buck reset did not clear state");
   a_pcl_cause: assert property (disable iff (rst)
      $rose(pulse_current_limit_flag) |-> over_hist_ff != 6'h00)
      else $error("pulse flag rose without sense above limit");
   a_pulse_disabled: assert property (disable iff (rst)
      $rose(pulse_current_limit_flag) |-> pulse_limit_response_select < 4'h7)
      else $error("pulse flag rose in a disabled mode");
   a_cp_off: assert property (disable iff (rst)
      !charge_pump_enable |-> bridge_state == `BR_OFF && !fault_out_n
         && thermal_shutdown_flag && power_stage_error_flag
         && overtemperature_any_flag)
      else $error("charge pump off without full shutdown");
   a_brake_reports: assert property (disable iff (rst)
      (bridge_state == `BR_HS_BRAKE || bridge_state == `BR_LS_BRAKE)
         |-> !fault_out_n && lock_current_flag && control_error_flag)
      else $error("brake without lock report");
   a_clear_tsd: assert property (disable iff (rst)
      $fell(thermal_shutdown_flag) && !$past(rst) && !$past(reset_request)
         |-> $past(clear_faults_cmd) || $past(clear_faults_cmd, 2))
      else $error("shutdown flag fell without clear");
   a_clear_warn: assert property (disable iff (rst)
      $fell(thermal_warning_flag) && !$past(rst) && !$past(reset_request)
         |-> $past(clear_faults_cmd) || $past(clear_faults_cmd, 2))
      else $error("warning flag fell without clear");
endmodule
bind motor_driver_fault_responder fault_responder_assertions u_chk
(
   .clk_sys, .rst, .sense_amp_output, .closed_loop, .closed_loop_limit_setting,
   .open_loop_limit_setting, .pulse_limit_response_select, .clear_faults_cmd,
   .fault_out_n, .bridge_state, .charge_pump_enable, .reset_request,
   .warning_report_enable, .pulse_current_limit_flag, .lock_current_flag,
   .control_error_flag, .power_stage_error_flag, .overtemperature_any_flag,
   .thermal_warning_flag, .thermal_shutdown_flag
);

// file: verif/tb_top.sv
`timescale 1ns/100ps
`include "fault_responder_defs.vh"
module tb_top;
   reg        clk_sys = 1'b0;
   reg        rst = 1'b1;
   reg        buck_ocp_raw = 1'b0;
   reg        temp_warn_raw = 1'b0;
   reg        temp_warn_hys_raw = 1'b0;
   reg        temp_tsd_raw = 1'b0;
   reg        temp_tsd_hys_raw = 1'b0;
   reg        closed_loop = 1'b1;
   reg        cfg_write = 1'b0;
   reg        cfg_warning_report = 1'b0;
   reg        clear_faults_cmd = 1'b0;
   reg [3:0]  pulse_limit_response_select = 4'h8;
   reg [3:0]  lock_current_response_select = 4'h9;
   reg [7:0]  lock_current_threshold = 8'hFF;
   reg [7:0]  sense_level = 8'h00;
   reg [7:0]  open_loop_limit_setting = 8'hC8;
   wire [7:0] sense_amp_output;
   wire [2:0] bridge_state;
   wire       pwm_cycle_start, fault_out_n, charge_pump_enable;
   wire       reset_request, warning_report_enable, pulse_current_limit_flag;
   wire       lock_current_flag, control_error_flag, power_stage_error_flag;
   wire       overtemperature_any_flag, thermal_warning_flag;
   wire       thermal_shutdown_flag;
   integer    num_errors = 0;
   integer    total_checks = 0;
   integer    i;
   // Pulse limit events expected only when the active threshold is below 8'h96
   wire       pl_on = closed_loop || open_loop_limit_setting < 8'h96;
   wire [7:0] pvec = {4'h0, bridge_state == `BR_RECIRC,
                      pulse_current_limit_flag, control_error_flag, ~fault_out_n};
   wire [7:0] lvec = {2'h0, bridge_state, lock_current_flag,
                      control_error_flag, ~fault_out_n};
   wire [7:0] tvec = {fault_out_n, charge_pump_enable, bridge_state == `BR_OFF,
                      power_stage_error_flag, overtemperature_any_flag,
                      thermal_warning_flag, thermal_shutdown_flag,
                      warning_report_enable};
   motor_driver_fault_responder dut
   (
      .clk_sys, .rst, .buck_ocp_raw, .temp_warn_raw, .temp_warn_hys_raw,
      .temp_tsd_raw, .temp_tsd_hys_raw, .sense_amp_output, .pwm_cycle_start,
      .closed_loop, .closed_loop_limit_setting(8'h64),
      .open_loop_limit_setting, .pulse_limit_response_select,
      .pulse_limit_retry_cycles(3'h1), .lock_current_threshold,
      .lock_current_deglitch_time(16'h0004), .lock_current_response_select,
      .lock_recovery_wait(24'h00_0014), .cfg_write, .cfg_warning_report,
      .clear_faults_cmd, .fault_out_n, .bridge_state, .charge_pump_enable,
      .reset_request, .warning_report_enable, .pulse_current_limit_flag,
      .lock_current_flag, .control_error_flag, .power_stage_error_flag,
      .overtemperature_any_flag, .thermal_warning_flag, .thermal_shutdown_flag
   );
   power_stage_model #(.PWM_PERIOD(32)) u_stage
   (
      .clk_sys, .rst, .bridge_state, .sense_level, .sense_amp_output,
      .pwm_cycle_start
   );
   always #25 clk_sys = ~clk_sys;
   ////////////////////////////////////////
   task tick(input integer n);
      repeat (n) @(posedge clk_sys);
   endtask
   task give_verdict;
      begin
         $display("checks %0d errors %0d", total_checks, num_errors);
         if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp)
         begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wait_pwm;
      integer n;
      begin
         n = 0;
         @(posedge clk_sys);
         while (pwm_cycle_start !== 1'b1 && n < 100)
         begin
            @(posedge clk_sys);
            n = n + 1;
         end
         if (n >= 100)
         begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t no pwm start", $time);
            give_verdict;
         end
      end
   endtask
   task pulse_clear;
      begin
         clear_faults_cmd <= 1'b1;
         tick(1);
         clear_faults_cmd <= 1'b0;
         tick(4);
      end
   endtask
   // Phases: 0 during event, 1 after sense drop, 2 and 3 after each PWM start
   function [7:0] pexp(input [3:0] m, input integer ph);
      reg live;
      begin
         live = (ph == 0) ? (m < 4'h6)
              : (ph == 1) ? (m < 4'h6 && m[2:1] != 2'h1)
              : (ph == 2) ? (m[3:1] == 3'h2) : 1'b0;
         if (live)
            pexp = {6'h03, ~m[0], ~m[0]};
         else if (m == 4'h6)
            pexp = 8'h06;
         else
            pexp = 8'h00;
      end
   endfunction
   function [7:0] lexp(input [3:0] m, input during);
      reg [2:0] br;
      begin
         br = (m[1:0] == 2'h0) ? `BR_OFF : {1'b0, m[1:0]};
         if (!m[3] && (during || !m[2]))
            lexp = {2'h0, br, 3'h7};
         else if (m == `LK_MODE_REPORT)
            lexp = 8'h06;
         else
            lexp = 8'h00;
      end
   endfunction
   // Start right after a PWM start so each phase lands in a known cycle
   task pulse_case(input [3:0] m, input cl);
      begin
         pulse_limit_response_select <= m;
         closed_loop <= cl;
         wait_pwm;
         sense_level <= 8'h96;
         tick(7);
         chk(pvec, pl_on ? pexp(m, 0) : 8'h00);
         sense_level <= 8'h32;
         tick(8);
         chk(pvec, pl_on ? pexp(m, 1) : 8'h00);
         wait_pwm;
         tick(4);
         chk(pvec, pl_on ? pexp(m, 2) : 8'h00);
         wait_pwm;
         tick(4);
         chk(pvec, pl_on ? pexp(m, 3) : 8'h00);
         pulse_clear;
         chk(pvec, 8'h00);
      end
   endtask
   task lock_case(input [3:0] m);
      begin
         lock_current_response_select <= m;
         sense_level <= 8'hC8;
         tick(12);
         chk(lvec, lexp(m, 1'b1));
         sense_level <= 8'h00;
         tick(30);
         chk(lvec, lexp(m, 1'b0));
         pulse_clear;
         chk(lvec, 8'h00);
      end
   endtask
   ////////////////////////////////////////
   initial
   begin
      tick(10);
      rst <= 1'b0;
      tick(3);
      chk(tvec, 8'hC0);
      temp_warn_raw <= 1'b1;
      temp_warn_hys_raw <= 1'b1;
      tick(6);
      chk(tvec, 8'hCC);
      cfg_warning_report <= 1'b1;
      cfg_write <= 1'b1;
      tick(1);
      cfg_write <= 1'b0;
      tick(4);
      chk(tvec, 8'h4D);
      temp_warn_raw <= 1'b0;
      tick(6);
      chk(tvec, 8'h4D);
      temp_warn_hys_raw <= 1'b0;
      tick(6);
      chk(tvec, 8'hCD);
      pulse_clear;
      chk(tvec, 8'hC1);
      temp_tsd_raw <= 1'b1;
      temp_tsd_hys_raw <= 1'b1;
      tick(6);
      chk(tvec, 8'h3B);
      pulse_clear;
      temp_tsd_raw <= 1'b0;
      tick(6);
      chk(tvec, 8'h3B);
      temp_tsd_hys_raw <= 1'b0;
      tick(6);
      chk(tvec, 8'hDB);
      pulse_clear;
      chk(tvec, 8'hC1);
      // A pin pulse shorter than the deglitch time must not reset
      buck_ocp_raw <= 1'b1;
      tick(10);
      buck_ocp_raw <= 1'b0;
      tick(2);
      chk({7'h00, reset_request}, 8'h00);
      buck_ocp_raw <= 1'b1;
      tick(30);
      chk({6'h00, reset_request, warning_report_enable}, 8'h02);
      buck_ocp_raw <= 1'b0;
      tick(8);
      chk({7'h00, reset_request}, 8'h00);
      // Last pass runs open loop with a threshold the sense level exceeds
      for (i = 0; i < 11; i = i + 1)
      begin
         if (i == 10)
            open_loop_limit_setting <= 8'h50;
         pulse_case(i >= 9 ? 4'h0 : i[3:0], i < 9);
      end
      pulse_limit_response_select <= 4'h8;
      lock_current_threshold <= 8'h78;
      for (i = 0; i < 11; i = i + 1)
         lock_case(i == 10 ? 4'hF : i[3:0]);
      give_verdict;
   end
endmodule
